// File: shared/pgc_pkg.sv
// package: register map, field layout and carrier types of the pattern generator control
//
// How it works
// - colour-invert bit set inverts the colour output; clear passes it through
// - auto-scroll set steps to next enabled pattern each frame period
// - 8-bit read-write indirect index register, reset zero, selects target
// - indirect data write stores the value into the indexed internal register
// - indirect data read returns the contents of the indexed internal register
package pgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAME_PERIOD = 8'h64;
  localparam logic [7:0] IDX_CONFIG       = 8'h65;
  localparam logic [7:0] IDX_IND_INDEX    = 8'h66;
  localparam logic [7:0] IDX_IND_VALUE    = 8'h67;
  localparam logic [7:0] IDX_ENABLE_MASK  = 8'h68;
  localparam logic [7:0] IDX_STATUS       = 8'h69;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_CONFIG       = 8'h00;
  localparam logic [7:0] RST_IND_INDEX    = 8'h00;
  localparam logic [7:0] RST_IND_VALUE    = 8'h00;
  localparam logic [7:0] RST_FRAME_PERIOD = 8'h01;
  localparam logic [7:0] RST_ENABLE_MASK  = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the configuration byte
  localparam int CFG_AUTO_SCROLL_BIT = 0;
  localparam int CFG_INVERT_BIT      = 1;
  localparam int CFG_TIMING_SEL_BIT  = 2;
  localparam int CFG_EXT_CLK_BIT     = 3;
  localparam int CFG_MODE18_BIT      = 4;
  localparam int CFG_CUSTOM_CB_BIT   = 5;
  localparam int CFG_CB_SCALE_BIT    = 6;

  // configuration byte, bit 7 reserved and read as zero
  typedef struct packed {
    logic reserved;
    logic cb_scale;
    logic custom_cb;
    logic mode18;
    logic ext_clk;
    logic timing_sel;
    logic invert;
    logic auto_scroll;
  } pgc_cfg_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pgc_apb_req_t;

endpackage : pgc_pkg

// File: hdl/pgc_scroll.sv
// auto-scroll sequencer: counts frames and steps through enabled patterns
`timescale 1ns/10ps
module pgc_scroll #(
  parameter int N_PAT = 8,
  parameter int SEL_W = 3
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // control
  input  wire logic             i_auto_scroll,
  input  wire logic             i_frame_start,
  input  wire logic [7:0]       i_frame_period,
  input  wire logic [N_PAT-1:0] i_enable_mask,
  // current pattern
  output logic      [SEL_W-1:0] o_pattern_sel
);

  logic [SEL_W-1:0] sel_q, sel_d;
  logic [7:0]       frames_q, frames_d;
  logic [SEL_W-1:0] next_sel;
  logic             found;
  logic [7:0]       period;

  // a period of zero behaves as one frame, so the counter never wraps forever
  assign period = (i_frame_period == 8'h00) ? 8'h01 : i_frame_period;

  // search forward from the current pattern for the next enabled one
  always_comb
  begin
    logic [SEL_W-1:0] cand;
    cand     = '0;
    next_sel = sel_q;
    found    = 1'b0;
    for (int k = 1; k <= N_PAT; k++)
    begin
      cand = SEL_W'((int'(sel_q) + k) % N_PAT);
      if (!found && i_enable_mask[cand])
      begin
        next_sel = cand;
        found    = 1'b1;
      end
    end
  end

  // frame counting and pattern stepping
  always_comb
  begin
    sel_d    = sel_q;
    frames_d = frames_q;
    if (!i_auto_scroll)
    begin
      frames_d = 8'h00; // hold pattern, restart timing on next enable
    end
    else if (i_frame_start)
    begin
      if (frames_q + 8'h01 >= period)
      begin
        frames_d = 8'h00;
        sel_d    = next_sel;
      end
      else
      begin
        frames_d = frames_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sel_q    <= '0;
      frames_q <= 8'h00;
    end
    else
    begin
      sel_q    <= sel_d;
      frames_q <= frames_d;
    end
  end

  assign o_pattern_sel = sel_q;

  a_scroll_hold : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !i_auto_scroll |=> $stable(sel_q))
    else $error("pattern changed while auto-scroll is off");

  a_scroll_step : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_auto_scroll && i_frame_start && (frames_q + 8'h01 >= period) && found)
    |=> sel_q == $past(next_sel))
    else $error("pattern did not step at end of frame period");

endmodule : pgc_scroll

// File: hdl/pgc_top.sv
// pattern generator control: apb register file, indirect register space, colour path
`timescale 1ns/10ps
module pgc_top #(
  parameter int N_PAT   = 8,
  parameter int SEL_W   = 3,
  parameter int PIX_W   = 24,
  parameter int IND_DEP = 256
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // apb slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [11:0]      i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic      [31:0]      o_prdata,
  output logic                  o_pslverr,
  // video path
  input  wire logic             i_frame_start,
  input  wire logic [PIX_W-1:0] i_pixel_rgb,
  output logic      [PIX_W-1:0] o_pixel_rgb,
  // generator controls
  output pgc_pkg::pgc_cfg_t     o_cfg,
  output logic      [SEL_W-1:0] o_pattern_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // bus request decode

  pgc_pkg::pgc_apb_req_t req;
  logic [7:0]            reg_idx;
  logic                  setup_ph;
  logic                  access_ph;
  logic                  wr_commit;
  logic                  mapped;

  // gather the bus into one carrier
  assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite,
                 addr: i_paddr, wdata: i_pwdata};

  // register index is the word address; low two bits ignored
  assign reg_idx   = req.addr[9:2];
  assign setup_ph  = req.sel && !req.enable;
  assign access_ph = req.sel && req.enable;
  // a write takes effect only at the edge where pready is seen high
  assign wr_commit = access_ph && o_pready && req.write && mapped;

  // upper address bits must be zero for a hit
  always_comb
  begin
    mapped = 1'b0;
    if (req.addr[11:10] == 2'b00)
    begin
      unique case (reg_idx)
        pgc_pkg::IDX_FRAME_PERIOD,
        pgc_pkg::IDX_CONFIG,
        pgc_pkg::IDX_IND_INDEX,
        pgc_pkg::IDX_IND_VALUE,
        pgc_pkg::IDX_ENABLE_MASK,
        pgc_pkg::IDX_STATUS:       mapped = 1'b1;
        default:                   mapped = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-visible registers

  pgc_pkg::pgc_cfg_t  cfg_q, cfg_d;
  logic [7:0]         ind_index_q, ind_index_d;
  logic [7:0]         ind_value_q, ind_value_d;
  logic [7:0]         frame_period_q, frame_period_d;
  logic [N_PAT-1:0]   enable_mask_q, enable_mask_d;

  // next values of the plain registers
  always_comb
  begin
    cfg_d          = cfg_q;
    ind_index_d    = ind_index_q;
    ind_value_d    = ind_value_q;
    frame_period_d = frame_period_q;
    enable_mask_d  = enable_mask_q;
    if (wr_commit)
    begin
      unique case (reg_idx)
        pgc_pkg::IDX_CONFIG:
        begin
          cfg_d          = pgc_pkg::pgc_cfg_t'(req.wdata[7:0]);
          cfg_d.reserved = 1'b0; // reserved bit never stores
        end
        pgc_pkg::IDX_IND_INDEX:    ind_index_d    = req.wdata[7:0];
        pgc_pkg::IDX_IND_VALUE:    ind_value_d    = req.wdata[7:0];
        pgc_pkg::IDX_FRAME_PERIOD: frame_period_d = req.wdata[7:0];
        pgc_pkg::IDX_ENABLE_MASK:  enable_mask_d  = req.wdata[N_PAT-1:0];
        default:                   ;
      endcase
    end
  end

  // the index is only ever changed by a direct write, never by an access
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_q          <= pgc_pkg::pgc_cfg_t'(pgc_pkg::RST_CONFIG);
      ind_index_q    <= pgc_pkg::RST_IND_INDEX;
      ind_value_q    <= pgc_pkg::RST_IND_VALUE;
      frame_period_q <= pgc_pkg::RST_FRAME_PERIOD;
      enable_mask_q  <= N_PAT'(pgc_pkg::RST_ENABLE_MASK);
    end
    else
    begin
      cfg_q          <= cfg_d;
      ind_index_q    <= ind_index_d;
      ind_value_q    <= ind_value_d;
      frame_period_q <= frame_period_d;
      enable_mask_q  <= enable_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect register space

  // no reset on the array: it is storage, and a reset loop would cost area
  logic [7:0] ind_mem [IND_DEP];
  logic       ind_wr;

  // the write lands in the selected entry on the same edge as the bus write
  assign ind_wr = wr_commit && (reg_idx == pgc_pkg::IDX_IND_VALUE);

  always_ff @(posedge i_sys_clk)
  begin
    if (ind_wr)
    begin
      ind_mem[ind_index_q] <= req.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  logic        pready_d;
  logic [31:0] prdata_d;
  logic        pslverr_d;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  // current pattern from the sequencer, declared here because status reads it
  logic [SEL_W-1:0] scroll_sel;

  // status shows the pattern currently selected by the sequencer
  assign status_word = {{(32-SEL_W){1'b0}}, scroll_sel};

  // read mux, narrow registers sit in the low bits
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (reg_idx)
      pgc_pkg::IDX_CONFIG:       rd_word = {24'h00_0000, cfg_q};
      pgc_pkg::IDX_IND_INDEX:    rd_word = {24'h00_0000, ind_index_q};
      // read returns the live contents of the indexed entry
      pgc_pkg::IDX_IND_VALUE:    rd_word = {24'h00_0000, ind_mem[ind_index_q]};
      pgc_pkg::IDX_FRAME_PERIOD: rd_word = {24'h00_0000, frame_period_q};
      pgc_pkg::IDX_ENABLE_MASK:  rd_word = {{(32-N_PAT){1'b0}}, enable_mask_q};
      pgc_pkg::IDX_STATUS:       rd_word = status_word;
      default:                   rd_word = 32'h0000_0000;
    endcase
  end

  // answer is prepared in the setup cycle so pready and data come from flops;
  // this gives zero wait states while keeping all outputs registered
  always_comb
  begin
    pready_d  = setup_ph;
    prdata_d  = o_prdata;
    pslverr_d = 1'b0;
    if (setup_ph)
    begin
      prdata_d  = (!req.write && mapped) ? rd_word : 32'h0000_0000;
      pslverr_d = !mapped;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= pready_d;
      o_prdata  <= prdata_d;
      o_pslverr <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern sequencer

  pgc_scroll #(
    .N_PAT (N_PAT),
    .SEL_W (SEL_W)
  ) u_scroll (
    .i_sys_clk      (i_sys_clk),
    .i_rstn         (i_rstn),
    .i_auto_scroll  (cfg_q.auto_scroll),
    .i_frame_start  (i_frame_start),
    .i_frame_period (frame_period_q),
    .i_enable_mask  (enable_mask_q),
    .o_pattern_sel  (scroll_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // colour output and control outputs

  logic [PIX_W-1:0] pixel_d;

  // one register stage; invert takes effect on the next pixel after the write
  always_comb
  begin
    pixel_d = cfg_q.invert ? ~i_pixel_rgb : i_pixel_rgb;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pixel_rgb   <= '0;
      o_cfg         <= pgc_pkg::pgc_cfg_t'(pgc_pkg::RST_CONFIG);
      o_pattern_sel <= '0;
    end
    else
    begin
      o_pixel_rgb   <= pixel_d;
      o_cfg         <= cfg_q;
      o_pattern_sel <= scroll_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_invert_path : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    1'b1 |=> o_pixel_rgb == ($past(cfg_q.invert) ? ~$past(i_pixel_rgb)
                                                 : $past(i_pixel_rgb)))
    else $error("colour output does not follow invert setting");

  a_invert_store : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wr_commit && reg_idx == pgc_pkg::IDX_CONFIG)
    |=> cfg_q.invert == $past(req.wdata[pgc_pkg::CFG_INVERT_BIT]))
    else $error("invert bit not stored");

  a_scroll_store : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wr_commit && reg_idx == pgc_pkg::IDX_CONFIG)
    |=> cfg_q.auto_scroll == $past(req.wdata[pgc_pkg::CFG_AUTO_SCROLL_BIT]))
    else $error("auto-scroll bit not stored");

  a_index_store : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wr_commit && reg_idx == pgc_pkg::IDX_IND_INDEX)
    |=> ind_index_q == $past(req.wdata[7:0]))
    else $error("indirect index write not stored");

  a_index_read : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (setup_ph && !req.write && reg_idx == pgc_pkg::IDX_IND_INDEX && mapped)
    |=> o_pready && o_prdata == {24'h00_0000, ind_index_q})
    else $error("indirect index read data wrong");

  a_index_steady : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !(wr_commit && reg_idx == pgc_pkg::IDX_IND_INDEX) |=> $stable(ind_index_q))
    else $error("indirect index changed without a direct write");

  a_refuse_keep : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (access_ph && !mapped) |=> $stable(ind_index_q) && $stable(cfg_q))
    else $error("refused access changed a register");

  a_refuse_error : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (setup_ph && !mapped) |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000)
    else $error("refused access not flagged");

  a_value_commit : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ind_wr |=> ind_mem[$past(ind_index_q)] == $past(req.wdata[7:0]))
    else $error("indirect write did not reach selected entry");

  a_value_holder : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ind_wr |=> ind_value_q == $past(req.wdata[7:0]))
    else $error("indirect data holder not loaded");

  a_value_read : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (setup_ph && !req.write && reg_idx == pgc_pkg::IDX_IND_VALUE && mapped)
    |=> o_pready && o_prdata == {24'h00_0000, ind_mem[ind_index_q]})
    else $error("indirect read data wrong");

  a_ready_timing : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    setup_ph |=> o_pready ##1 !o_pready)
    else $error("access not answered in one cycle");

endmodule : pgc_top

// File: sim/tb.sv
// self-checking testbench for the pattern generator control block
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
  ////////////////////////////////////////////////////////////////////////////
  // design signals and bench state
  logic               i_sys_clk     = 1'b0;
  logic               i_rstn        = 1'b0;
  logic               i_psel        = 1'b0;
  logic               i_penable     = 1'b0;
  logic               i_pwrite      = 1'b0;
  logic [11:0]        i_paddr       = 12'h000;
  logic [31:0]        i_pwdata      = 32'h0;
  logic               i_frame_start = 1'b0;
  logic [23:0]        i_pixel_rgb   = 24'h0;
  logic               o_pready;
  logic [31:0]        o_prdata;
  logic               o_pslverr;
  logic [23:0]        o_pixel_rgb;
  pgc_pkg::pgc_cfg_t  o_cfg;
  logic [2:0]         o_pattern_sel;
  int                 errors        = 0;
  int                 checks_done   = 0;
  int                 cycles        = 0;
  logic [33:0]        aq[$];
  logic [23:0]        pq[$];
  logic [10:0]        sq[$];
  logic [33:0]        e_apb;
  logic [23:0]        e_pix;
  logic [10:0]        e_snap;
  logic               pv            = 1'b0;
  logic               pv_d          = 1'b0;
  logic               sc            = 1'b0;
  logic [7:0]         ind[256];
  logic [7:0]         ix[6];
  logic [7:0]         dv;
  logic [23:0]        r;

  pgc_top i_dut (
    .i_sys_clk     (i_sys_clk),
    .i_rstn        (i_rstn),
    .i_psel        (i_psel),
    .i_penable     (i_penable),
    .i_pwrite      (i_pwrite),
    .i_paddr       (i_paddr),
    .i_pwdata      (i_pwdata),
    .o_pready      (o_pready),
    .o_prdata      (o_prdata),
    .o_pslverr     (o_pslverr),
    .i_frame_start (i_frame_start),
    .i_pixel_rgb   (i_pixel_rgb),
    .o_pixel_rgb   (o_pixel_rgb),
    .o_cfg         (o_cfg),
    .o_pattern_sel (o_pattern_sel)
  );

  // 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // closing report, shared by the main sequence and the watchdog
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // watchdog: the whole run needs a few hundred cycles at most
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitors: apb answers on the sampling edge, video outputs mid-cycle
  always @(posedge i_sys_clk)
  begin
    pv_d <= pv;
    if (i_psel && i_penable && o_pready === 1'b1)
    begin
      e_apb = aq.pop_front();
      if (e_apb[33])
        `CHK(o_prdata, e_apb[31:0])
      `CHK(o_pslverr, e_apb[32])
    end
  end

  always @(negedge i_sys_clk)
  begin
    if (pv_d)
    begin
      e_pix = pq.pop_front();
      `CHK(o_pixel_rgb, e_pix)
    end
    if (sc)
    begin
      e_snap = sq.pop_front();
      `CHK({o_cfg, o_pattern_sel}, e_snap)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drivers; xfer leaves psel up so a next setup may follow at once
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      input logic err, input logic [1:0] hi = 2'b00);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= {hi, idx, 2'b00};
    i_pwdata  <= d;
    aq.push_back({~w, err, (err ? 32'h0 : d)});
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1)
      @(posedge i_sys_clk);
  endtask : xfer

  task automatic idle(input int n);
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask : idle

  task automatic snap(input logic [7:0] cfg, input logic [2:0] sel);
    sq.push_back({cfg, sel});
    sc <= 1'b1;
    @(posedge i_sys_clk);
    sc <= 1'b0;
    @(posedge i_sys_clk);
  endtask : snap

  // random colour stream; expectation follows the bench's own invert setting
  task automatic pix(input int n, input logic inv);
    repeat (n)
    begin
      r = 24'($urandom);
      i_pixel_rgb <= r;
      pv          <= 1'b1;
      pq.push_back(inv ? ~r : r);
      @(posedge i_sys_clk);
    end
    pv <= 1'b0;
    @(posedge i_sys_clk);
  endtask : pix

  // spaced frame pulses, then time for the two output flops to settle
  task automatic frames(input int n);
    repeat (n)
    begin
      i_frame_start <= 1'b1;
      @(posedge i_sys_clk);
      i_frame_start <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
    end
  endtask : frames

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h9c56));
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    // reset values, read back to back
    xfer(0, 8'h65, 32'h00, 0);
    xfer(0, 8'h66, 32'h00, 0);
    xfer(0, 8'h64, 32'h01, 0);
    xfer(0, 8'h68, 32'hff, 0);
    idle(1);
    snap(8'h00, 3'h0);
    // refused accesses must not disturb the index
    xfer(1, 8'h10, 32'h5a, 1);
    xfer(0, 8'h10, 32'h00, 1);
    xfer(1, 8'h66, 32'h33, 1, 2'b01);
    xfer(0, 8'h66, 32'h00, 0);
    // config storage; top bit reads zero
    xfer(1, 8'h65, 32'hff, 0);
    xfer(0, 8'h65, 32'h7f, 0);
    xfer(1, 8'h65, 32'h02, 0);
    idle(3);
    snap(8'h02, 3'h0);
    pix(8, 1'b1);
    xfer(1, 8'h65, 32'h00, 0);
    idle(3);
    pix(8, 1'b0);
    // indirect space, including both index extremes
    for (int k = 0; k < 6; k++)
    begin
      ix[k] = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      dv = 8'($urandom);
      ind[ix[k]] = dv;
      xfer(1, 8'h66, {24'h0, ix[k]}, 0);
      xfer(1, 8'h67, {24'h0, dv}, 0);
      xfer(0, 8'h67, {24'h0, dv}, 0);
      xfer(0, 8'h66, {24'h0, ix[k]}, 0);
    end
    for (int k = 5; k >= 0; k--)
    begin
      xfer(1, 8'h66, {24'h0, ix[k]}, 0);
      xfer(0, 8'h67, {24'h0, ind[ix[k]]}, 0);
      xfer(0, 8'h66, {24'h0, ix[k]}, 0);
    end
    // scroll: period 2, patterns 0, 2 and 5 enabled
    xfer(1, 8'h64, 32'h02, 0);
    xfer(1, 8'h68, 32'h25, 0);
    idle(1);
    frames(3);
    snap(8'h00, 3'h0);
    xfer(1, 8'h65, 32'h01, 0);
    idle(3);
    frames(1);
    snap(8'h01, 3'h0);
    frames(1);
    snap(8'h01, 3'h2);
    xfer(0, 8'h69, 32'h02, 0);
    idle(1);
    frames(2);
    snap(8'h01, 3'h5);
    frames(2);
    snap(8'h01, 3'h0);
    // zero period acts as one frame; an empty mask holds the pattern
    xfer(1, 8'h64, 32'h00, 0);
    idle(1);
    frames(1);
    snap(8'h01, 3'h2);
    xfer(1, 8'h68, 32'h00, 0);
    idle(1);
    frames(2);
    snap(8'h01, 3'h2);
    // mid-run reset brings registers and outputs back to reset values
    xfer(1, 8'h66, 32'h5a, 0);
    idle(1);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    xfer(0, 8'h65, 32'h00, 0);
    xfer(0, 8'h66, 32'h00, 0);
    idle(1);
    snap(8'h00, 3'h0);
    wrap_up();
  end
endmodule : tb
